// ---- i2c_pkg.sv ----
// Functional notes
// R01: answer address 10111 plus two strap bits
// R02: straps give addresses 5Ch up to 5Fh
// R03: also answer a strap-independent generic address
// R04: bit1 strap followed continuously
// R05: bit2 strap latched 768us after reset
// R06: address byte lsb: 0 write, 1 read
// R07: start and stop while clock high
// R08: bytes of eight bits, msb first
// R09: receiver acknowledges each byte low
// R10: data changes only while clock low
// R11: bits sampled on clock rising edge
// R12: write: address, register, data, stop
// R13: every written data byte acknowledged
// R14: read: register write, repeated start, read
// R15: master acknowledges bytes it wants continued
// R16: master not-acknowledge ends read, then stop
// R17: register address advances after each byte; code keeps it after a read byte the master does not acknowledge
package i2c_pkg;
    localparam int CLK_PERIOD_NS = 25;
    localparam logic [4:0] ADDR_UPPER = 5'h17;
    localparam logic [6:0] GENERIC_ADDR = 7'h00;
    localparam int STRAP_DELAY_NS = 768000;
    localparam int STRAP_DELAY_CYCLES = (STRAP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SCL_PERIOD_NS = 2500;
    localparam int QTR_CYCLES = (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
    localparam logic [7:0] SOFT_RST_REG = 8'h00;
    localparam int SOFT_RST_BIT = 7;
    localparam logic [3:0] BITS_DATA = 4'h8;
    localparam logic [3:0] BITS_FRAME = 4'h9;

    typedef enum logic [3:0] {
        T_IDLE = 4'b0000,
        T_ADDR = 4'b0001,
        T_ACK_A = 4'b0010,
        T_REG = 4'b0011,
        T_ACK_R = 4'b0100,
        T_WDATA = 4'b0101,
        T_ACK_W = 4'b0110,
        T_TX = 4'b0111,
        T_MACK = 4'b1000
    } target_state_t;

    typedef enum logic [1:0] {
        M_IDLE = 2'b00,
        M_START = 2'b01,
        M_FRAME = 2'b10,
        M_STOP = 2'b11
    } ctrl_state_t;

    typedef enum logic [2:0] {
        ST_ADDR_W = 3'b000,
        ST_REG = 3'b001,
        ST_WDATA = 3'b010,
        ST_ADDR_R = 3'b011,
        ST_RDATA = 3'b100
    } ctrl_step_t;
endpackage

// ---- i2c_if.sv ----
`timescale 1ns/1ps
interface i2c_if;
    logic scl_o;
    logic scl_oe_n;
    logic sda_m_o;
    logic sda_m_oe_n;
    logic sda_s_o;
    logic sda_s_oe_n;
    logic scl;
    logic sda;

    // open-drain wires with pull-ups: low only while someone drives low
    assign scl = !(!scl_oe_n && !scl_o);
    assign sda = !((!sda_m_oe_n && !sda_m_o) || (!sda_s_oe_n && !sda_s_o));

    modport target (
        input scl,
        input sda,
        output sda_s_o,
        output sda_s_oe_n
    );

    modport controller (
        input scl,
        input sda,
        output scl_o,
        output scl_oe_n,
        output sda_m_o,
        output sda_m_oe_n
    );
endinterface

// ---- i2c_target.sv ----
`timescale 1ns/1ps
module i2c_target
    import i2c_pkg::*;
#(
    parameter int STRAP_CYCLES = STRAP_DELAY_CYCLES,
    parameter logic [6:0] GEN_ADDR = GENERIC_ADDR
) (
    input logic sys_clk,
    input logic sys_rst,
    i2c_if.target bus,
    input logic hw_rst_n,
    input logic addr_select_bit1_pin,
    input logic addr_select_bit2_pin,
    input logic [7:0] reg_rdata,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    output logic soft_rst,
    output logic [6:0] dev_addr
);
    localparam int CW = $clog2(STRAP_CYCLES + 1);
    localparam logic [CW-1:0] STRAP_LAST = CW'(STRAP_CYCLES - 1);

    logic [4:0] pin_in;
    logic [4:0] filt;
    logic scl_f;
    logic sda_f;
    logic hw_f;
    logic scl_d;
    logic sda_d;
    logic hw_d;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic byte_end;
    logic ack_end;
    logic [CW-1:0] strap_cnt;
    logic strap_run;
    logic addr_select_bit2_pin_latched;
    target_state_t state;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic [7:0] tx;
    logic rw;
    logic sda_oe_n;

    assign pin_in = {bus.scl, bus.sda, hw_rst_n, addr_select_bit1_pin, addr_select_bit2_pin};

    // three stages; a change is taken once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_sync
            logic st1;
            logic st2;
            logic st3;
            logic held;
            always_ff @(posedge sys_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    st1 <= 1'b1;
                    st2 <= 1'b1;
                    st3 <= 1'b1;
                    held <= 1'b1;
                end else begin
                    st1 <= pin_in[gi];
                    st2 <= st1;
                    st3 <= st2;
                    if (st2 == st3) begin
                        held <= st3;
                    end
                end
            end
            assign filt[gi] = held;
        end
    endgenerate

    assign scl_f = filt[4];
    assign sda_f = filt[3];
    assign hw_f = filt[2];

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            hw_d <= 1'b1;
        end else begin
            scl_d <= scl_f;
            sda_d <= sda_f;
            hw_d <= hw_f;
        end
    end

    assign scl_rise = scl_f && !scl_d;
    assign scl_fall = !scl_f && scl_d;
    assign start_cond = scl_f && scl_d && sda_d && !sda_f; // [R07]
    assign stop_cond = scl_f && scl_d && !sda_d && sda_f; // [R07]
    assign byte_end = scl_fall && (bit_cnt == BITS_DATA);
    assign ack_end = scl_fall && (bit_cnt == BITS_FRAME);

    // bit2 strap: one sample per reset, the power-up release counts as one
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            strap_cnt <= '0;
            strap_run <= 1'b1;
            addr_select_bit2_pin_latched <= 1'b0;
        end else if ((hw_f && !hw_d) || soft_rst) begin
            strap_cnt <= '0; // [R05]
            strap_run <= 1'b1;
        end else if (strap_run) begin
            if (strap_cnt == STRAP_LAST) begin
                strap_run <= 1'b0;
                addr_select_bit2_pin_latched <= filt[0]; // [R05]
            end else begin
                strap_cnt <= strap_cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            dev_addr <= {ADDR_UPPER, 2'b00};
        end else begin
            dev_addr <= {ADDR_UPPER, addr_select_bit2_pin_latched, filt[1]}; // [R01] [R02] [R04]
        end
    end

    // bit counter and receive shifter; the ack slot counts as the ninth bit
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
        end else if (start_cond || state == T_IDLE) begin
            bit_cnt <= 4'h0;
        end else if (scl_rise) begin
            bit_cnt <= bit_cnt + 4'h1;
            shreg <= {shreg[6:0], sda_f}; // [R08] [R11]
        end else if (ack_end) begin
            bit_cnt <= 4'h0;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= T_IDLE;
            sda_oe_n <= 1'b1;
            rw <= 1'b0;
            tx <= 8'h00;
            reg_addr <= 8'h00;
            reg_wdata <= 8'h00;
            reg_wr <= 1'b0;
            reg_rd <= 1'b0;
            soft_rst <= 1'b0;
        end else begin
            reg_wr <= 1'b0;
            reg_rd <= 1'b0;
            soft_rst <= 1'b0;
            if (!hw_f || stop_cond) begin
                state <= T_IDLE;
                sda_oe_n <= 1'b1;
            end else if (start_cond) begin
                state <= T_ADDR; // [R14]
                sda_oe_n <= 1'b1;
            end else begin
                unique case (state)
                    T_IDLE: begin
                        sda_oe_n <= 1'b1;
                    end
                    T_ADDR: begin
                        if (byte_end) begin
                            if (shreg[7:1] == dev_addr || shreg[7:1] == GEN_ADDR) begin // [R03]
                                sda_oe_n <= 1'b0; // [R09]
                                rw <= shreg[0]; // [R06]
                                state <= T_ACK_A;
                            end else begin
                                state <= T_IDLE;
                            end
                        end
                    end
                    T_ACK_A: begin
                        if (ack_end) begin
                            if (rw) begin
                                tx <= reg_rdata; // [R14]
                                sda_oe_n <= reg_rdata[7]; // [R10]
                                reg_rd <= 1'b1;
                                state <= T_TX;
                            end else begin
                                sda_oe_n <= 1'b1;
                                state <= T_REG; // [R12]
                            end
                        end
                    end
                    T_REG: begin
                        if (byte_end) begin
                            reg_addr <= shreg;
                            sda_oe_n <= 1'b0; // [R09]
                            state <= T_ACK_R;
                        end
                    end
                    T_ACK_R: begin
                        if (ack_end) begin
                            sda_oe_n <= 1'b1;
                            state <= T_WDATA;
                        end
                    end
                    T_WDATA: begin
                        if (byte_end) begin
                            reg_wdata <= shreg;
                            reg_wr <= 1'b1;
                            soft_rst <= (reg_addr == SOFT_RST_REG) && shreg[SOFT_RST_BIT];
                            sda_oe_n <= 1'b0; // [R13]
                            state <= T_ACK_W;
                        end
                    end
                    T_ACK_W: begin
                        if (ack_end) begin
                            sda_oe_n <= 1'b1;
                            reg_addr <= reg_addr + 8'h01; // [R17]
                            state <= T_WDATA;
                        end
                    end
                    T_TX: begin
                        if (byte_end) begin
                            sda_oe_n <= 1'b1;
                            state <= T_MACK;
                        end else if (scl_fall) begin
                            tx <= {tx[6:0], 1'b0}; // [R08]
                            sda_oe_n <= tx[6]; // [R10]
                        end
                    end
                    T_MACK: begin
                        // advance early so reg_rdata has settled by the fall
                        if (scl_rise && !sda_f) begin
                            reg_addr <= reg_addr + 8'h01; // [R17]
                        end
                        if (ack_end) begin
                            if (!shreg[0]) begin
                                tx <= reg_rdata; // [R15]
                                sda_oe_n <= reg_rdata[7];
                                reg_rd <= 1'b1;
                                state <= T_TX;
                            end else begin
                                sda_oe_n <= 1'b1; // [R16]
                                state <= T_IDLE;
                            end
                        end
                    end
                    default: begin
                        state <= T_IDLE;
                        sda_oe_n <= 1'b1;
                    end
                endcase
            end
        end
    end

    assign bus.sda_s_oe_n = sda_oe_n;
    // open drain: only ever pulls low
    assign bus.sda_s_o = 1'b0;
endmodule

// ---- i2c_controller.sv ----
`timescale 1ns/1ps
module i2c_controller
    import i2c_pkg::*;
#(
    parameter int QTR = QTR_CYCLES,
    parameter int LEN_W = 4
) (
    input logic sys_clk,
    input logic sys_rst,
    i2c_if.controller bus,
    input logic cmd_valid,
    input logic cmd_read,
    input logic [6:0] cmd_dev_addr,
    input logic [7:0] cmd_reg_addr,
    input logic [LEN_W-1:0] cmd_len,
    input logic [7:0] wr_data,
    output logic cmd_ready,
    output logic wr_take,
    output logic [7:0] rd_data,
    output logic rd_valid,
    output logic done,
    output logic nack
);
    localparam int QW = $clog2(QTR + 1);
    localparam logic [QW-1:0] QTR_LAST = QW'(QTR - 1);

    logic st1;
    logic st2;
    logic st3;
    logic sda_f;
    ctrl_state_t state;
    ctrl_step_t step;
    logic [QW-1:0] qcnt;
    logic [1:0] phase;
    logic tick;
    logic [8:0] tx9;
    logic [7:0] rx8;
    logic [3:0] bit_i;
    logic [LEN_W-1:0] remaining;
    logic rd_mode;
    logic [6:0] dev;
    logic [7:0] regad;
    logic scl_oe_n;
    logic sda_oe_n;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st1 <= 1'b1;
            st2 <= 1'b1;
            st3 <= 1'b1;
            sda_f <= 1'b1;
        end else begin
            st1 <= bus.sda;
            st2 <= st1;
            st3 <= st2;
            if (st2 == st3) begin
                sda_f <= st3;
            end
        end
    end

    assign tick = (state != M_IDLE) && (qcnt == QTR_LAST);

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            qcnt <= '0;
            phase <= 2'b00;
        end else if (state == M_IDLE || tick) begin
            qcnt <= '0;
            phase <= (state == M_IDLE) ? 2'b00 : phase + 2'b01;
        end else begin
            qcnt <= qcnt + 1'b1;
        end
    end

    // quarters: 0 clock low, 1 set data, 2 clock high, 3 sample or condition
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= M_IDLE;
            step <= ST_ADDR_W;
            cmd_ready <= 1'b1;
            scl_oe_n <= 1'b1;
            sda_oe_n <= 1'b1;
            tx9 <= 9'h1ff;
            rx8 <= 8'h00;
            bit_i <= 4'h0;
            remaining <= '0;
            rd_mode <= 1'b0;
            dev <= 7'h00;
            regad <= 8'h00;
            wr_take <= 1'b0;
            rd_data <= 8'h00;
            rd_valid <= 1'b0;
            done <= 1'b0;
            nack <= 1'b0;
        end else begin
            wr_take <= 1'b0;
            rd_valid <= 1'b0;
            done <= 1'b0;
            if (state == M_IDLE) begin
                if (cmd_valid && cmd_ready) begin
                    cmd_ready <= 1'b0;
                    dev <= cmd_dev_addr;
                    regad <= cmd_reg_addr;
                    rd_mode <= cmd_read;
                    remaining <= cmd_len;
                    nack <= 1'b0;
                    tx9 <= {cmd_dev_addr, 1'b0, 1'b1}; // [R06] [R12] [R14]
                    step <= ST_ADDR_W;
                    state <= M_START;
                end
            end else if (tick) begin
                unique case (phase)
                    2'b00: begin
                        scl_oe_n <= 1'b0;
                    end
                    2'b01: begin
                        // data only moves while the clock is held low
                        unique case (state)
                            M_FRAME: sda_oe_n <= tx9[8]; // [R08] [R10]
                            M_START: sda_oe_n <= 1'b1;
                            default: sda_oe_n <= 1'b0;
                        endcase
                    end
                    2'b10: begin
                        scl_oe_n <= 1'b1;
                    end
                    default: begin
                        if (state == M_START) begin
                            sda_oe_n <= 1'b0; // [R07]
                            bit_i <= 4'h0;
                            state <= M_FRAME;
                        end else if (state == M_STOP) begin
                            sda_oe_n <= 1'b1; // [R07]
                            state <= M_IDLE;
                            cmd_ready <= 1'b1;
                            done <= 1'b1;
                        end else if (bit_i != BITS_DATA) begin
                            rx8 <= {rx8[6:0], sda_f}; // [R11]
                            tx9 <= {tx9[7:0], 1'b1};
                            bit_i <= bit_i + 4'h1;
                        end else begin
                            bit_i <= 4'h0;
                            if (step != ST_RDATA && sda_f) begin
                                nack <= 1'b1; // [R09]
                                state <= M_STOP;
                            end else begin
                                unique case (step)
                                    ST_ADDR_W: begin
                                        tx9 <= {regad, 1'b1};
                                        step <= ST_REG;
                                    end
                                    ST_REG: begin
                                        if (rd_mode) begin
                                            tx9 <= {dev, 1'b1, 1'b1}; // [R14]
                                            step <= ST_ADDR_R;
                                            state <= M_START;
                                        end else begin
                                            tx9 <= {wr_data, 1'b1}; // [R12]
                                            wr_take <= 1'b1;
                                            step <= ST_WDATA;
                                        end
                                    end
                                    ST_WDATA: begin
                                        if (remaining <= LEN_W'(1)) begin
                                            state <= M_STOP; // [R12]
                                        end else begin
                                            remaining <= remaining - 1'b1;
                                            tx9 <= {wr_data, 1'b1};
                                            wr_take <= 1'b1;
                                        end
                                    end
                                    ST_ADDR_R: begin
                                        tx9 <= {8'hff, remaining <= LEN_W'(1)}; // [R15] [R16]
                                        step <= ST_RDATA;
                                    end
                                    default: begin
                                        rd_data <= rx8;
                                        rd_valid <= 1'b1;
                                        if (remaining <= LEN_W'(1)) begin
                                            state <= M_STOP; // [R16]
                                        end else begin
                                            remaining <= remaining - 1'b1;
                                            tx9 <= {8'hff, remaining == LEN_W'(2)}; // [R15]
                                        end
                                    end
                                endcase
                            end
                        end
                    end
                endcase
            end
        end
    end

    assign bus.scl_oe_n = scl_oe_n;
    assign bus.sda_m_oe_n = sda_oe_n;
    assign bus.scl_o = 1'b0;
    assign bus.sda_m_o = 1'b0;
endmodule

// ---- i2c_register_access_slave_monitor.sv ----
`timescale 1ns/1ps
module i2c_register_access_slave_monitor (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_m_oe_n,
    input wire logic sda_s_oe_n
);
    logic scl_q;
    logic sda_q;
    logic rw;
    logic [3:0] bitn;
    logic [7:0] nbyte;
    wire rise = scl && !scl_q;
    wire start_c = scl && scl_q && sda_q && !sda;
    wire stop_c = scl && scl_q && !sda_q && sda;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
        end
    end

    // the clock rise before a stop or repeated start also counts, as bit 1
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            bitn <= 4'h0;
            nbyte <= 8'h00;
        end else if (start_c || stop_c) begin
            bitn <= 4'h0;
            nbyte <= 8'h00;
        end else if (rise) begin
            bitn <= (bitn == 4'h9) ? 4'h1 : bitn + 4'h1;
            nbyte <= (bitn == 4'h9) ? nbyte + 8'h01 : nbyte;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst)
            rw <= 1'b0;
        else if (rise && bitn == 4'h7 && nbyte == 8'h00)
            rw <= sda;
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    sequence s_rise;
        rise;
    endsequence
    sequence s_stop;
        stop_c;
    endsequence

    a_ack_write_bytes: assert property (s_rise ##1
        (bitn == 4'h9 && nbyte != 8'h00 && !rw) |-> !sda_s_oe_n)
        else $error("write byte not acknowledged");
    a_release_master_ack: assert property (s_rise ##1
        (bitn == 4'h9 && nbyte != 8'h00 && rw) |-> sda_s_oe_n)
        else $error("target drives during master ack");
    a_master_quiet_read: assert property (s_rise ##1
        (bitn inside {[4'h2:4'h8]} && nbyte != 8'h00 && rw) |-> sda_m_oe_n)
        else $error("master drives read data");
    a_target_quiet_master: assert property (s_rise ##1
        (bitn inside {[4'h1:4'h8]} && (nbyte == 8'h00 || !rw)) |-> sda_s_oe_n)
        else $error("target drives master bit");
    a_target_change_low: assert property ($changed(sda_s_oe_n) |-> !scl)
        else $error("target data changed with clock high");
    a_start_clock_low: assert property (start_c |-> ##[1:40] !scl)
        else $error("no clock after start");
    a_stop_after_frame: assert property (s_stop |-> bitn == 4'h1)
        else $error("stop inside a byte");
    a_quiet_after_stop: assert property (s_stop |=> sda_s_oe_n [*8])
        else $error("target drives after stop");
endmodule

// ---- i2c_register_access_slave_test.sv ----
`timescale 1ns/1ps
module i2c_register_access_slave_test;
    import i2c_pkg::*;
    localparam int STRAP_N = 50;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic hw_rst_n = 1'b1;
    logic addr_select_bit1_pin = 1'b0;
    logic addr_select_bit2_pin = 1'b1;
    logic cmd_valid = 1'b0;
    logic cmd_read = 1'b0;
    logic [6:0] cmd_dev_addr = 7'h00;
    logic [7:0] cmd_reg_addr = 8'h00;
    logic [3:0] cmd_len = 4'h1;
    logic [7:0] wr_data = 8'h00;
    logic [7:0] reg_rdata, reg_addr, reg_wdata, rd_data, ra;
    logic reg_wr, reg_rd, soft_rst, cmd_ready, wr_take, rd_valid, done, nack;
    logic [6:0] dev_addr;
    logic [7:0] regs [256];
    logic [7:0] shadow [256];
    logic [7:0] wr_buf [16];
    logic [15:0] exp_q [$];
    int wr_idx, soft_cnt, rd_cnt, rd_exp, err_count, check_count;

    always #12.5 sys_clk = ~sys_clk;
    assign reg_rdata = regs[reg_addr];

    i2c_if bus_if ();
    i2c_target #(.STRAP_CYCLES(STRAP_N)) i_i2c_target (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .bus(bus_if), .hw_rst_n(hw_rst_n), .addr_select_bit1_pin(addr_select_bit1_pin),
        .addr_select_bit2_pin(addr_select_bit2_pin), .reg_rdata(reg_rdata),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .soft_rst(soft_rst), .dev_addr(dev_addr));
    i2c_controller #(.QTR(8)) i_i2c_controller (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .bus(bus_if), .cmd_valid(cmd_valid), .cmd_read(cmd_read), .cmd_dev_addr(cmd_dev_addr),
        .cmd_reg_addr(cmd_reg_addr), .cmd_len(cmd_len), .wr_data(wr_data),
        .cmd_ready(cmd_ready), .wr_take(wr_take), .rd_data(rd_data), .rd_valid(rd_valid),
        .done(done), .nack(nack));
    i2c_register_access_slave_monitor i_monitor (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .scl(bus_if.scl), .sda(bus_if.sda), .sda_m_oe_n(bus_if.sda_m_oe_n),
        .sda_s_oe_n(bus_if.sda_s_oe_n));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp || $isunknown(exp)) begin
            err_count++;
            $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic pop_chk(input logic [15:0] seen);
        logic [15:0] e;
        e = 16'hxxxx;
        if (exp_q.size() > 0)
            e = exp_q.pop_front();
        check(seen, e);
    endtask

    // user register store behind the target
    always @(posedge sys_clk) begin
        if (reg_wr === 1'b1)
            regs[reg_addr] <= reg_wdata;
    end

    always @(negedge sys_clk) begin
        if (wr_take === 1'b1) begin
            wr_data = wr_buf[wr_idx[3:0]];
            wr_idx++;
        end
    end

    always @(negedge sys_clk) begin
        if (reg_wr === 1'b1)
            pop_chk({reg_addr, reg_wdata});
        if (rd_valid === 1'b1)
            pop_chk({8'h00, rd_data});
        if (done === 1'b1)
            pop_chk({15'h0000, nack});
        if (soft_rst === 1'b1)
            soft_cnt++;
        if (reg_rd === 1'b1)
            rd_cnt++;
    end

    // register 0 always gets bit 7 set, so every write there is a soft reset
    task automatic xfer(input logic rd, input logic [6:0] dev, input logic [7:0] a,
            input int n, input logic ok);
        int k;
        for (k = 0; k < n; k++) begin
            if (!rd) begin
                wr_buf[k] = (a + 8'(k) == SOFT_RST_REG) ? 8'h80 : 8'($urandom);
                if (ok)
                    exp_q.push_back({a + 8'(k), wr_buf[k]});
                if (ok)
                    shadow[a + 8'(k)] = wr_buf[k];
            end else begin
                exp_q.push_back({8'h00, shadow[a + 8'(k)]});
                rd_exp++;
            end
        end
        exp_q.push_back({15'h0000, !ok});
        wr_data = wr_buf[0];
        wr_idx = 1;
        cmd_read = rd;
        cmd_dev_addr = dev;
        cmd_reg_addr = a;
        cmd_len = 4'(n);
        cmd_valid = 1'b1;
        do @(negedge sys_clk); while (cmd_ready === 1'b1);
        cmd_valid = 1'b0;
        k = 0;
        while (done !== 1'b1 && k < 20000) begin
            @(negedge sys_clk);
            k++;
        end
        check({15'h0000, done}, 16'h0001);
        @(negedge sys_clk);
    endtask

    task automatic strap(input logic [1:0] c);
        addr_select_bit1_pin = c[0];
        addr_select_bit2_pin = c[1];
        hw_rst_n = 1'b0;
        repeat (8) @(negedge sys_clk);
        hw_rst_n = 1'b1;
        repeat (STRAP_N + 10) @(negedge sys_clk);
        check({9'h000, dev_addr}, {9'h000, ADDR_UPPER, c});
    endtask

    initial begin
        void'($urandom(32'h527f5a16));
        repeat (5) @(negedge sys_clk);
        sys_rst = 1'b0;
        repeat (STRAP_N - 10) @(negedge sys_clk);
        check({9'h000, dev_addr}, 16'h005c);
        repeat (20) @(negedge sys_clk);
        check({9'h000, dev_addr}, 16'h005e);
        addr_select_bit2_pin = 1'b0;
        addr_select_bit1_pin = 1'b1;
        repeat (10) @(negedge sys_clk);
        check({9'h000, dev_addr}, 16'h005f);
        for (int c = 0; c < 4; c++) begin
            strap(2'(c));
            xfer(1'b0, {ADDR_UPPER, 2'(c)}, 8'h40 + 8'(c), 1, 1'b1);
            xfer(1'b0, {ADDR_UPPER, ~2'(c)}, 8'h44, 1, 1'b0);
            xfer(1'b1, {ADDR_UPPER, 2'(c)}, 8'h40 + 8'(c), 1, 1'b1);
        end
        addr_select_bit2_pin = 1'b0;
        xfer(1'b0, 7'h5f, 8'hfe, 3, 1'b1);
        repeat (STRAP_N + 10) @(negedge sys_clk);
        check({9'h000, dev_addr}, 16'h005d);
        xfer(1'b1, 7'h5d, 8'hfe, 3, 1'b1);
        ra = 8'h20 + 8'($urandom % 64);
        xfer(1'b0, 7'h5d, ra, 4, 1'b1);
        xfer(1'b1, 7'h5d, ra, 4, 1'b1);
        xfer(1'b0, GENERIC_ADDR, 8'h60, 2, 1'b1);
        xfer(1'b1, GENERIC_ADDR, 8'h60, 2, 1'b1);
        check(16'(soft_cnt), 16'h0001);
        check(16'(rd_cnt), 16'(rd_exp));
        check(16'(exp_q.size()), 16'h0000);
        finish_test;
    end

    // the whole sequence needs roughly 20500 cycles
    initial begin
        repeat (60000) @(posedge sys_clk);
        err_count++;
        finish_test;
    end
endmodule
